// file: fhbq_pkg.sv
// Purpose: shared constants and types of the floppy host bus qualifier
// Assumes: byte wide host bus, one core clock
// Notes: bit positions of operations and status bytes live here only
package fhbq_pkg;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int CTL_W = 2;
    localparam int DRV_W = 4;
    // operations register layout
    localparam int OPS_DMA_EN_BIT = 3;
    localparam int OPS_DRV_LSB = 0;
    localparam int OPS_DRV_W = 2;
    localparam int OPS_MOTOR_LSB = 4;
    // main status byte layout
    localparam int MSR_RQM_BIT = 7;
    localparam int MSR_DIO_BIT = 6;
    localparam int MSR_NDMA_BIT = 5;
    localparam int MSR_BUSY_BIT = 4;
    // control readback: media swap status bit
    localparam int CTL_SWAP_BIT = 7;
    localparam logic [7:0] OPS_RESET = 8'h00;
    localparam logic [1:0] CTL_RESET = 2'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [2:0] {
        MODE_BASE = 3'b001,
        MODE_SPECIAL = 3'b010,
        MODE_PCAT = 3'b100
    } fhbq_mode_t;

    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_READ = 3'b010,
        ACC_WRITE = 3'b100
    } fhbq_acc_t;
endpackage

// file: fhbq_qual_if.sv
// Purpose: carries mode and grant/terminal count qualification signals
// Assumes: all signals synchronous to the core clock
// Notes: top drives the raw side, qualifier drives the qualified side
interface fhbq_qual_if;
    import fhbq_pkg::*;
    fhbq_mode_t mode;
    logic dma_en;
    logic grant_n;
    logic done_in;
    logic exec_dma;
    logic grant_ok;
    logic done_ok;
    modport top (output mode, dma_en, grant_n, done_in, exec_dma, input grant_ok, done_ok);
    modport qual (input mode, dma_en, grant_n, done_in, exec_dma, output grant_ok, done_ok);
endinterface

// file: fhbq_fifo.sv
// Purpose: synchronous FIFO between host writes and the command core
// Assumes: single clock, push ignored when full, pop ignored when empty
// Notes: depth must be a power of two
module fhbq_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign in_ready = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem[rp_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
        nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end

    // storage carries no reset: contents are only read once counted in
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_ff] <= in_data;
        end
    end
endmodule

// file: fhbq_qualifier.sv
// Purpose: qualifies dma grant and terminal count by mode and dma enable
// Assumes: grant is active low, terminal count active high
// Notes: purely combinational, the top registers done_ok and uses grant_ok unregistered
module fhbq_qualifier (
    // qualification signals
    fhbq_qual_if.qual q
);
    import fhbq_pkg::*;
    logic grant_raw;

    assign grant_raw = !q.grant_n;

    always_comb begin
        // base mode honours grant unconditionally; the others need dma enable
        q.grant_ok = grant_raw && (q.mode == MODE_BASE || q.dma_en);
        case (q.mode)
            MODE_BASE: q.done_ok = q.exec_dma ? (q.done_in && grant_raw) : q.done_in;
            MODE_SPECIAL: q.done_ok = q.exec_dma ? (q.done_in && q.grant_ok) : q.done_in;
            MODE_PCAT: q.done_ok = q.done_in && q.grant_ok;
            default: q.done_ok = 1'b0;
        endcase
    end
endmodule

// file: floppy_host_bus_qualifier.sv
// Purpose: host side bus port of a floppy subsystem controller
// Assumes: host strobes and selects are already synchronous to clk
// Notes: the command core sits behind the core_* ports
// Summary of operation
// - Data and status strobes count only while chip select is low; register loads ignore it.
// - Register select high picks data, low picks main status.
// - During a qualified read the data or status byte is driven.
// - A qualified write latches the bus byte into the buffer.
// - Grant acts like chip select with register select high.
// - In special or AT mode grant needs the dma enable bit.
// - Base mode: DMA commands gate terminal count by grant, PIO takes it raw.
// - In AT or special mode, grant gating also needs dma enable.
// - In AT mode terminal count is always gated by grant.
// - PIO commands in AT mode end with an abnormal termination flag.
// - Host byte port is eight bits, bidirectional, three-state.
// - One dma request per byte in DMA execution.
// - Dma request driven in base mode, else only with dma enable.
// - Interrupt on command end and on PIO byte requests.
// - Interrupt driven in base mode, else only with dma enable.
// - Media swap sense and gate inputs are active low.
// - Rate, drive and motor controls sit in latched registers.
// - Four host-visible locations: data, eight-bit main status, operations, control.
// - Operations load takes full byte; control load takes two low bits.
// - Control decode read with gate low puts swap status on bit 7.
// - Reset idles access logic, clears latched registers and requests, forces base mode.
module floppy_host_bus_qualifier (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host strobes and selects
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic cs_n,
    input wire logic register_select_line,
    input wire logic dma_grant_input_n,
    input wire logic transfer_done_input,
    input wire logic ops_reg_load_decode_n,
    input wire logic ctl_reg_load_decode_n,
    // host byte lines, split
    input wire logic [fhbq_pkg::BYTE_W-1:0] host_byte_lines_i,
    output logic [fhbq_pkg::BYTE_W-1:0] host_byte_lines_o,
    output logic host_byte_lines_oe,
    // request pins, split
    output logic dma_request,
    output logic dma_request_oe,
    output logic int_request,
    output logic int_request_oe,
    // media swap pins
    input wire logic media_swap_gate_n,
    input wire logic media_swap_sense_n,
    // command core status
    input wire fhbq_pkg::fhbq_mode_t core_mode,
    input wire logic core_mode_load,
    input wire logic core_exec_dma,
    input wire logic core_busy,
    input wire logic core_dir_to_host,
    input wire logic [fhbq_pkg::DRV_W-1:0] core_drive_busy,
    input wire logic core_byte_req,
    input wire logic core_cmd_done,
    input wire logic core_irq_clr,
    // command core read data
    input wire logic [fhbq_pkg::BYTE_W-1:0] core_rd_byte,
    input wire logic core_rd_valid,
    output logic core_rd_ack,
    // command core write data stream
    output logic [fhbq_pkg::BYTE_W-1:0] core_wr_byte,
    output logic core_wr_valid,
    input wire logic core_wr_ready,
    output logic host_wr_ready,
    // qualified events and latched controls
    output logic transfer_done_q,
    output logic abnormal_end,
    output fhbq_pkg::fhbq_mode_t current_mode,
    output logic [fhbq_pkg::BYTE_W-1:0] ops_byte,
    output logic [fhbq_pkg::OPS_DRV_W-1:0] drive_select,
    output logic [fhbq_pkg::DRV_W-1:0] motor_on,
    output logic [fhbq_pkg::CTL_W-1:0] data_rate
);
    import fhbq_pkg::*;

    fhbq_qual_if qif ();
    fhbq_mode_t mode_ff, nxt_mode;
    fhbq_acc_t acc_ff, nxt_acc;
    logic [BYTE_W-1:0] ops_ff, nxt_ops, rd_byte_ff, nxt_rd_byte, buf_ff, nxt_buf;
    logic [CTL_W-1:0] ctl_ff, nxt_ctl;
    logic drq_ff, nxt_drq, irq_ff, nxt_irq, abn_ff, nxt_abn;
    logic done_prev_ff, nxt_done_prev, done_pulse_ff, nxt_done_pulse;
    logic rd_ack_ff, nxt_rd_ack;
    logic dma_en, data_sel, status_sel, rd_start, wr_start, push_req;
    logic ops_wr, ctl_wr, ctl_rd, grant_start, oe_on;
    logic [BYTE_W-1:0] status_byte, ctl_read_byte;

    assign dma_en = ops_ff[OPS_DMA_EN_BIT];
    assign qif.mode = mode_ff;
    assign qif.dma_en = dma_en;
    assign qif.grant_n = dma_grant_input_n;
    assign qif.done_in = transfer_done_input;
    assign qif.exec_dma = core_exec_dma;

    fhbq_qualifier u_qual (
        .q(qif.qual)
    );

    // host access decode
    assign data_sel = (!cs_n && register_select_line) || qif.grant_ok;
    assign status_sel = !cs_n && !register_select_line && !qif.grant_ok;
    // control register reads bypass chip select, like its load decode
    assign ctl_rd = !ctl_reg_load_decode_n && !media_swap_gate_n;
    assign rd_start = (acc_ff == ACC_IDLE) && !rd_n && wr_n && (data_sel || status_sel || ctl_rd);
    assign wr_start = (acc_ff == ACC_IDLE) && !wr_n && rd_n;
    assign ops_wr = wr_start && !ops_reg_load_decode_n;
    assign ctl_wr = wr_start && !ctl_reg_load_decode_n;
    // a write to the status location is dropped, never pushed
    assign push_req = wr_start && data_sel;
    assign grant_start = qif.grant_ok && (rd_start || wr_start);

    always_comb begin
        status_byte = BYTE_ZERO;
        status_byte[MSR_RQM_BIT] = core_dir_to_host ? core_rd_valid : host_wr_ready;
        status_byte[MSR_DIO_BIT] = core_dir_to_host;
        status_byte[MSR_NDMA_BIT] = core_busy && !core_exec_dma;
        status_byte[MSR_BUSY_BIT] = core_busy;
        status_byte[DRV_W-1:0] = core_drive_busy;
        ctl_read_byte = BYTE_ZERO;
        ctl_read_byte[CTL_SWAP_BIT] = !media_swap_sense_n;
    end

    // access sequencer: one capture per strobe, held until release
    always_comb begin
        nxt_rd_byte = rd_byte_ff;
        nxt_rd_ack = 1'b0;
        case (acc_ff)
            ACC_IDLE: begin
                nxt_acc = rd_start ? ACC_READ : (wr_start ? ACC_WRITE : ACC_IDLE);
                if (rd_start) begin
                    if (data_sel) begin
                        nxt_rd_byte = core_rd_byte;
                        nxt_rd_ack = 1'b1;
                    end else if (status_sel) begin
                        nxt_rd_byte = status_byte;
                    end else begin
                        nxt_rd_byte = ctl_read_byte;
                    end
                end
            end
            ACC_READ: nxt_acc = rd_n ? ACC_IDLE : ACC_READ;
            ACC_WRITE: nxt_acc = wr_n ? ACC_IDLE : ACC_WRITE;
            default: nxt_acc = ACC_IDLE;
        endcase
    end

    always_comb begin
        nxt_mode = mode_ff;
        if (core_mode_load) begin
            case (core_mode)
                MODE_BASE, MODE_SPECIAL, MODE_PCAT: nxt_mode = core_mode;
                default: nxt_mode = MODE_BASE;
            endcase
        end
        nxt_ops = ops_wr ? host_byte_lines_i : ops_ff;
        nxt_ctl = ctl_wr ? host_byte_lines_i[CTL_W-1:0] : ctl_ff;
        nxt_buf = push_req ? host_byte_lines_i : buf_ff;
        // hardware set wins over the clear in the same cycle
        nxt_drq = (core_byte_req && core_exec_dma) || (drq_ff && !grant_start);
        nxt_irq = core_cmd_done || (core_byte_req && !core_exec_dma) || (irq_ff && !core_irq_clr);
        if (core_cmd_done) begin
            nxt_abn = (mode_ff == MODE_PCAT) && !core_exec_dma;
        end else begin
            nxt_abn = abn_ff && !core_irq_clr;
        end
        nxt_done_prev = qif.done_ok;
        nxt_done_pulse = qif.done_ok && !done_prev_ff;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_ff <= MODE_BASE;
            acc_ff <= ACC_IDLE;
            ops_ff <= OPS_RESET;
            ctl_ff <= CTL_RESET;
            buf_ff <= BYTE_ZERO;
            rd_byte_ff <= BYTE_ZERO;
            rd_ack_ff <= 1'b0;
            drq_ff <= 1'b0;
            irq_ff <= 1'b0;
            abn_ff <= 1'b0;
            done_prev_ff <= 1'b0;
            done_pulse_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            acc_ff <= nxt_acc;
            ops_ff <= nxt_ops;
            ctl_ff <= nxt_ctl;
            buf_ff <= nxt_buf;
            rd_byte_ff <= nxt_rd_byte;
            rd_ack_ff <= nxt_rd_ack;
            drq_ff <= nxt_drq;
            irq_ff <= nxt_irq;
            abn_ff <= nxt_abn;
            done_prev_ff <= nxt_done_prev;
            done_pulse_ff <= nxt_done_pulse;
        end
    end

    // the push sits one cycle behind the strobe, from the buffer register
    logic push_ff, nxt_push;
    assign nxt_push = push_req;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            push_ff <= 1'b0;
        end else begin
            push_ff <= nxt_push;
        end
    end

    // a full fifo shows as not-ready in status; bytes pushed then are lost
    fhbq_fifo #(
        .W(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push_ff),
        .in_data(buf_ff),
        .in_ready(host_wr_ready),
        .out_valid(core_wr_valid),
        .out_data(core_wr_byte),
        .out_ready(core_wr_ready)
    );

    assign oe_on = (acc_ff == ACC_READ);
    assign host_byte_lines_oe = oe_on;
    assign host_byte_lines_o = rd_byte_ff;
    assign dma_request = drq_ff;
    assign dma_request_oe = (mode_ff == MODE_BASE) || dma_en;
    assign int_request = irq_ff;
    assign int_request_oe = (mode_ff == MODE_BASE) || dma_en;
    assign core_rd_ack = rd_ack_ff;
    assign transfer_done_q = done_pulse_ff;
    assign abnormal_end = abn_ff;
    assign current_mode = mode_ff;
    assign ops_byte = ops_ff;
    assign drive_select = ops_ff[OPS_DRV_LSB +: OPS_DRV_W];
    assign motor_on = ops_ff[OPS_MOTOR_LSB +: DRV_W];
    assign data_rate = ctl_ff;

    a_read_drive: assert property (@(posedge clk) disable iff (rst)
        rd_start |=> host_byte_lines_oe until_with rd_n)
        else $error("read strobe not driven");
    a_read_bound: assert property (@(posedge clk) disable iff (rst)
        host_byte_lines_oe |-> $past(!rd_n))
        else $error("bus driven without read strobe");
    a_write_select: assert property (@(posedge clk) disable iff (rst)
        push_ff |-> $past(!cs_n || qif.grant_ok))
        else $error("write taken without select");
    a_status_nowrite: assert property (@(posedge clk) disable iff (rst)
        (wr_start && status_sel) |=> !push_ff)
        else $error("status location write pushed");
    a_write_latch: assert property (@(posedge clk) disable iff (rst)
        push_req |=> (buf_ff == $past(host_byte_lines_i)) && push_ff)
        else $error("write byte not latched");
    a_ctl_load: assert property (@(posedge clk) disable iff (rst)
        ctl_wr |=> data_rate == $past(host_byte_lines_i[CTL_W-1:0]))
        else $error("control bits not loaded");
    a_drq_gate: assert property (@(posedge clk) disable iff (rst)
        (mode_ff != MODE_BASE && !ops_ff[OPS_DMA_EN_BIT]) |-> !dma_request_oe && !int_request_oe)
        else $error("request pins driven while gated");
    a_drq_once: assert property (@(posedge clk) disable iff (rst)
        (dma_request && grant_start && !core_byte_req) |=> !dma_request)
        else $error("dma request not cleared by grant");
    a_irq_done: assert property (@(posedge clk) disable iff (rst)
        core_cmd_done |=> int_request)
        else $error("no interrupt at command end");
    a_abn_pio: assert property (@(posedge clk) disable iff (rst)
        (core_cmd_done && mode_ff == MODE_PCAT && !core_exec_dma) |=> abnormal_end)
        else $error("missing abnormal termination");
    // the pulse is registered once, so its cause sits exactly one cycle back
    a_done_atmode: assert property (@(posedge clk) disable iff (rst)
        (transfer_done_q && $past(mode_ff) == MODE_PCAT)
        |-> $past(!dma_grant_input_n && dma_en))
        else $error("terminal count not gated by grant");
    a_mode_base: assert property (@(posedge clk)
        $fell(rst) |-> current_mode == MODE_BASE && !dma_request && !int_request)
        else $error("reset did not force base mode");
    a_grant_gate: assert property (@(posedge clk) disable iff (rst)
        (mode_ff != MODE_BASE && !dma_en) |-> !qif.grant_ok)
        else $error("grant honoured without dma enable");
    a_grant_data: assert property (@(posedge clk) disable iff (rst)
        (qif.grant_ok && rd_start) |=> host_byte_lines_o == $past(core_rd_byte))
        else $error("grant read did not return data byte");
    a_done_base: assert property (@(posedge clk) disable iff (rst)
        (mode_ff == MODE_BASE && !core_exec_dma && transfer_done_input && !done_prev_ff)
        |=> transfer_done_q)
        else $error("programmed transfer end not taken");
    a_req_base_oe: assert property (@(posedge clk) disable iff (rst)
        mode_ff == MODE_BASE |-> dma_request_oe && int_request_oe)
        else $error("request pins not driven in base mode");
    a_irq_pio: assert property (@(posedge clk) disable iff (rst)
        (core_byte_req && !core_exec_dma) |=> int_request)
        else $error("no interrupt for programmed byte");

    c_dma_read: cover property (@(posedge clk) disable iff (rst) grant_start && rd_start);
    c_pio_write: cover property (@(posedge clk) disable iff (rst) push_req && !qif.grant_ok);
    c_done_pulse: cover property (@(posedge clk) disable iff (rst) transfer_done_q);
    c_fifo_full: cover property (@(posedge clk) disable iff (rst) !host_wr_ready);
endmodule

// file: fhbq_dma_model.sv
// Purpose: system dma controller model facing the host bus qualifier
// Assumes: request seen at a rising edge, strobes launched 1 ns after an edge
// Notes: stall sets extra cycles before the grant, to exercise slow answers
module fhbq_dma_model (
    // clock
    input wire logic clk,
    // device request pin
    input wire logic req,
    input wire logic req_oe,
    // host byte lines as driven by the device
    input wire logic bus_oe,
    input wire logic [7:0] bus_o,
    // control and results
    input wire logic [3:0] stall,
    output logic grant_n,
    output logic rd_n,
    output logic [7:0] got,
    output int taken
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        grant_n = 1'b1;
        rd_n = 1'b1;
        got = 8'h00;
        taken = 0;
        forever begin
            @(posedge clk);
            // a floating request pin is never trusted
            if (req === 1'b1 && req_oe === 1'b1) begin
                repeat (stall) @(posedge clk);
                #1;
                // grant stands in for chip select, only a read strobe is used
                grant_n = 1'b0;
                rd_n = 1'b0;
                do @(posedge clk); while (bus_oe !== 1'b1);
                got = bus_o;
                taken++;
                #1;
                grant_n = 1'b1;
                rd_n = 1'b1;
                repeat (2) @(posedge clk);
            end
        end
    end
endmodule

// file: floppy_host_bus_qualifier_test.sv
// Purpose: self-checking bench of the floppy host bus qualifier
// Assumes: inputs change 1 ns after the rising edge
// Notes: 8'hee from host_rd marks a read that the device never answered
module floppy_host_bus_qualifier_test;
    timeunit 1ns;
    timeprecision 100ps;
    import fhbq_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd_h = 1'b1, wr_n = 1'b1, cs_n = 1'b1, rs = 1'b0;
    logic grant_h = 1'b1, eot = 1'b0, ops_n = 1'b1, ctl_n = 1'b1, gate_n = 1'b1, sense_n = 1'b1;
    logic [7:0] bus_i = 8'h00, rd_byte = 8'h00, bus_o, ops_byte, got;
    logic bus_oe, dreq, dreq_oe, irq, irq_oe, rd_ack, wr_valid, host_wr_ready, eot_q, abn;
    logic mode_load = 1'b0, exec_dma = 1'b0, busy = 1'b0, dir = 1'b0, byte_req = 1'b0;
    logic cmd_done = 1'b0, irq_clr = 1'b0, rd_valid = 1'b0, wr_ready = 1'b0, eot_seen = 1'b0;
    logic [3:0] drv_busy = 4'h0, motor_on, stall = 4'h2;
    logic [7:0] wr_byte;
    logic [1:0] drive_select, data_rate;
    logic m_grant_n, m_rd_n, ack_seen = 1'b0;
    fhbq_mode_t mode = MODE_BASE, cur_mode;
    int error_cnt = 0, tests_run = 0, taken;
    always #2 clk = ~clk;
    always @(posedge clk) if (eot_q === 1'b1) eot_seen <= 1'b1;
    fhbq_dma_model dma (.clk(clk), .req(dreq), .req_oe(dreq_oe), .bus_oe(bus_oe),
        .bus_o(bus_o), .stall(stall), .grant_n(m_grant_n), .rd_n(m_rd_n), .got(got),
        .taken(taken));
    floppy_host_bus_qualifier uut (.clk(clk), .rst(rst), .rd_n(rd_h & m_rd_n), .wr_n(wr_n),
        .cs_n(cs_n), .register_select_line(rs), .dma_grant_input_n(grant_h & m_grant_n),
        .transfer_done_input(eot), .ops_reg_load_decode_n(ops_n),
        .ctl_reg_load_decode_n(ctl_n), .host_byte_lines_i(bus_i), .host_byte_lines_o(bus_o),
        .host_byte_lines_oe(bus_oe), .dma_request(dreq), .dma_request_oe(dreq_oe),
        .int_request(irq), .int_request_oe(irq_oe), .media_swap_gate_n(gate_n),
        .media_swap_sense_n(sense_n), .core_mode(mode), .core_mode_load(mode_load),
        .core_exec_dma(exec_dma), .core_busy(busy), .core_dir_to_host(dir),
        .core_drive_busy(drv_busy), .core_byte_req(byte_req), .core_cmd_done(cmd_done),
        .core_irq_clr(irq_clr), .core_rd_byte(rd_byte), .core_rd_valid(rd_valid),
        .core_rd_ack(rd_ack), .core_wr_byte(wr_byte), .core_wr_valid(wr_valid),
        .core_wr_ready(wr_ready), .host_wr_ready(host_wr_ready), .transfer_done_q(eot_q),
        .abnormal_end(abn), .current_mode(cur_mode), .ops_byte(ops_byte),
        .drive_select(drive_select), .motor_on(motor_on), .data_rate(data_rate));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask
    task automatic set_mode(input fhbq_mode_t m);
        mode = m;
        pulse(mode_load);
    endtask
    task automatic host_rd(input logic cs, input logic sel, input logic ctl,
        output logic [7:0] d);
        int k;
        k = 0;
        cs_n = cs;
        rs = sel;
        ctl_n = ctl;
        rd_h = 1'b0;
        step(1);
        while (bus_oe !== 1'b1 && k < 4) begin
            step(1);
            k++;
        end
        d = (bus_oe === 1'b1) ? bus_o : 8'hee;
        ack_seen = rd_ack;
        rd_h = 1'b1;
        cs_n = 1'b1;
        ctl_n = 1'b1;
        step(2);
    endtask
    // register select stays high on every write, status writes are illegal
    task automatic host_wr(input logic cs, input logic ops, input logic ctl,
        input logic [7:0] b);
        cs_n = cs;
        rs = 1'b1;
        ops_n = ops;
        ctl_n = ctl;
        bus_i = b;
        wr_n = 1'b0;
        step(1);
        wr_n = 1'b1;
        cs_n = 1'b1;
        ops_n = 1'b1;
        ctl_n = 1'b1;
        bus_i = ~b;
        step(1);
    endtask
    task automatic t_reset();
        check({1'b0, cur_mode, host_wr_ready, dreq_oe, irq_oe, bus_oe}, 8'h1e);
        check({ops_byte[7:1], dreq}, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_status();
        logic [7:0] d;
        busy = 1'b1;
        drv_busy = 4'h5;
        host_rd(1'b0, 1'b0, 1'b1, d);
        check(d, 8'hb5);
        check({7'h0, ack_seen}, 8'h00);
        host_rd(1'b1, 1'b0, 1'b1, d);
        check(d, 8'hee);
        rd_byte = 8'h3c;
        host_rd(1'b0, 1'b1, 1'b1, d);
        check(d, 8'h3c);
        check({7'h0, ack_seen}, 8'h01);
        $display("t_status done");
    endtask
    task automatic t_regs();
        host_wr(1'b1, 1'b0, 1'b1, 8'h5b);
        check(ops_byte, 8'h5b);
        check({drive_select, 2'h0, motor_on}, 8'hc5);
        host_wr(1'b1, 1'b1, 1'b0, 8'hfe);
        check({data_rate, ops_byte[5:0]}, 8'h9b);
        $display("t_regs done");
    endtask
    task automatic t_fifo();
        logic [7:0] d;
        for (int i = 0; i < FIFO_DEPTH; i++) host_wr(1'b0, 1'b1, 1'b1, 8'h10 + i[7:0]);
        check({7'h0, host_wr_ready}, 8'h00);
        host_rd(1'b0, 1'b0, 1'b1, d);
        check(d, 8'h35);
        host_wr(1'b0, 1'b1, 1'b1, 8'hff);
        // drain with a stall cycle between pops
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            check({7'h0, wr_valid}, 8'h01);
            check(wr_byte, 8'h10 + i[7:0]);
            wr_ready = 1'b1;
            step(1);
            wr_ready = 1'b0;
            step(1);
        end
        check({6'h0, wr_valid, host_wr_ready}, 8'h01);
        $display("t_fifo done");
    endtask
    task automatic t_swap();
        logic [7:0] d;
        gate_n = 1'b0;
        sense_n = 1'b0;
        host_rd(1'b1, 1'b0, 1'b0, d);
        check(d, 8'h80);
        sense_n = 1'b1;
        host_rd(1'b1, 1'b0, 1'b0, d);
        check(d, 8'h00);
        gate_n = 1'b1;
        host_rd(1'b1, 1'b0, 1'b0, d);
        check(d, 8'hee);
        $display("t_swap done");
    endtask
    task automatic t_dma();
        int k;
        exec_dma = 1'b1;
        rd_byte = 8'ha7;
        pulse(byte_req);
        k = 0;
        while (taken < 1 && k < 20) begin
            step(1);
            k++;
        end
        check(got, 8'ha7);
        step(3);
        check({7'h0, dreq}, 8'h00);
        set_mode(MODE_SPECIAL);
        host_wr(1'b1, 1'b0, 1'b1, 8'h00);
        check({6'h0, dreq_oe, irq_oe}, 8'h00);
        host_wr(1'b1, 1'b0, 1'b1, 8'h08);
        check({6'h0, dreq_oe, irq_oe}, 8'h03);
        $display("t_dma done");
    endtask
    task automatic eot_case(input fhbq_mode_t m, input logic en, input logic ex,
        input logic g, input logic exp);
        set_mode(m);
        host_wr(1'b1, 1'b0, 1'b1, {4'h0, en, 3'h0});
        exec_dma = ex;
        grant_h = ~g;
        step(1);
        eot_seen = 1'b0;
        eot = 1'b1;
        step(4);
        eot = 1'b0;
        grant_h = 1'b1;
        check({7'h0, eot_seen}, {7'h0, exp});
        step(2);
    endtask
    task automatic t_eot();
        eot_case(MODE_BASE, 1'b0, 1'b0, 1'b0, 1'b1);
        eot_case(MODE_BASE, 1'b0, 1'b1, 1'b0, 1'b0);
        eot_case(MODE_BASE, 1'b0, 1'b1, 1'b1, 1'b1);
        eot_case(MODE_SPECIAL, 1'b0, 1'b1, 1'b1, 1'b0);
        eot_case(MODE_SPECIAL, 1'b1, 1'b1, 1'b1, 1'b1);
        eot_case(MODE_PCAT, 1'b1, 1'b0, 1'b0, 1'b0);
        eot_case(MODE_PCAT, 1'b1, 1'b0, 1'b1, 1'b1);
        $display("t_eot done");
    endtask
    task automatic t_irq();
        set_mode(MODE_PCAT);
        exec_dma = 1'b0;
        pulse(cmd_done);
        step(1);
        check({6'h0, irq, abn}, 8'h03);
        pulse(irq_clr);
        step(1);
        check({6'h0, irq, abn}, 8'h00);
        set_mode(MODE_BASE);
        pulse(byte_req);
        step(1);
        check({6'h0, irq, dreq}, 8'h02);
        pulse(cmd_done);
        step(1);
        check({7'h0, abn}, 8'h00);
        set_mode(MODE_PCAT);
        rst = 1'b1;
        step(1);
        rst = 1'b0;
        check({5'h0, cur_mode}, {5'h0, MODE_BASE});
        $display("t_irq done");
    endtask
    task automatic wrap_up();
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #40000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        step(2);
        rst = 1'b0;
        step(1);
        t_reset();
        t_status();
        t_regs();
        t_fifo();
        t_swap();
        t_dma();
        t_eot();
        t_irq();
        wrap_up();
    end
endmodule
